// *** hdl/ras_consts.svh ***
// constants for the return-address stack predictor
`ifndef RAS_CONSTS_SVH
`define RAS_CONSTS_SVH
`define RAS_ADDR_W       32
`define RAS_DEPTH        8
`define RAS_PTR_W        3
`define RAS_CNT_W        4
`define RAS_IQ_ENTRIES   8
`define RAS_IQ_IDX_W     3
`define RAS_DISP_WIN     3
`define RAS_BO_SPECIAL   5'h14
`define RAS_BI_SPECIAL   5'h1F
`define RAS_INSTR_BYTES  32'h0000_0004
`endif

// *** hdl/ras_pkg.sv ***
// types shared by the return-address stack predictor files
package ras_pkg;
  // kind of branch presented by fetch
  typedef enum logic [3:0] {
    RAS_BR_OTHER = 4'h1,
    RAS_BR_CALL  = 4'h2,
    RAS_BR_RET   = 4'h4,
    RAS_BR_CTR   = 4'h8
  } ras_br_kind_t;
  // return resolution state
  typedef enum logic [2:0] {
    RAS_ST_IDLE  = 3'h1,
    RAS_ST_PRED  = 3'h2,
    RAS_ST_STALL = 3'h4
  } ras_state_t;
endpackage

// *** hdl/ras_stack_if.sv ***
// push/pop/flush carrier between predictor control and stack storage
`timescale 1ns/100ps
interface ras_stack_if;
  logic        push;
  logic        pop;
  logic        flush;
  logic [31:0] push_addr;
  logic [31:0] top_addr;
  logic        top_valid;
  modport ctrl  (output push, pop, flush, push_addr, input top_addr, top_valid);
  modport store (input push, pop, flush, push_addr, output top_addr, top_valid);
endinterface

// *** hdl/ras_stack.sv ***
// circular return-address stack storage
`timescale 1ns/100ps
`include "ras_consts.svh"
module ras_stack
  import ras_pkg::*;
(
  // clock, reset, enable
  input  wire logic  i_clk,
  input  wire logic  i_reset,
  input  wire logic  i_ce,
  // control side
  ras_stack_if.store s
);
  logic [`RAS_PTR_W-1:0]  top_q, top_d;
  logic [`RAS_CNT_W-1:0]  cnt_q, cnt_d;
  logic [`RAS_ADDR_W-1:0] mem_q [`RAS_DEPTH];
  logic [`RAS_ADDR_W-1:0] mem_d [`RAS_DEPTH];

  // ==========================================================
  // next state: full push overwrites the oldest slot by wrapping
  always_comb begin
    top_d = top_q;
    cnt_d = cnt_q;
    for (int i = 0; i < `RAS_DEPTH; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (s.flush) begin
      cnt_d = '0;
    end else if (s.push && !s.pop) begin
      top_d = top_q + 1'b1;
      mem_d[top_q + 1'b1] = s.push_addr;
      if (cnt_q != `RAS_CNT_W'(`RAS_DEPTH)) begin
        cnt_d = cnt_q + 1'b1;
      end
    end else if (s.pop && !s.push && cnt_q != '0) begin
      top_d = top_q - 1'b1;
      cnt_d = cnt_q - 1'b1;
    end else if (s.pop && s.push) begin
      mem_d[top_q] = s.push_addr; // replace top
    end
  end

  // registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      top_q <= '0;
      cnt_q <= '0;
      for (int i = 0; i < `RAS_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (i_ce) begin
      top_q <= top_d;
      cnt_q <= cnt_d;
      for (int i = 0; i < `RAS_DEPTH; i++) begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  assign s.top_addr  = mem_q[top_q];
  assign s.top_valid = (cnt_q != '0);
endmodule

// *** hdl/ras_predictor.sv ***
// return-address stack predictor with branch folding decisions
`timescale 1ns/100ps
`include "ras_consts.svh"
// Contract
// - every call branch but the capture form pushes its return address; every call writes return_link_reg
// - a return predicts its target from the stack top
// - stack prediction is used when the real link value is not yet ready
// - a return that consults the stack pops one entry
// - without prediction a return stalls until link value is forwarded
// - call form BO=20, BI=31, target next instruction pushes nothing
// - that form still writes next address into return_link_reg
// - that form is forced not-taken, no taken bubble
// - a return address mispredict flushes the whole stack
// - after flush returns find no prediction and stall for the link value
// - only branches not writing link nor changing count may fold
// - taken foldable branches fold immediately, no dispatch slot
// - not-taken foldable branch in entries 0-2 is handled normally
// - foldable branch in entries 3-7 removed the cycle after execution
// - entries 0-2 form the dispatch window, in program order
// - link/count moves forward early from first integer station when ready
module ras_predictor
  import ras_pkg::*;
(
  // clock, reset, enable
  input  wire logic                       i_clk,
  input  wire logic                       i_reset,
  input  wire logic                       i_ce,
  // branch presented for execution
  input  wire logic                       i_br_valid,
  input  wire logic [3:0]                 i_br_kind,
  input  wire logic                       i_br_link,
  input  wire logic                       i_br_taken,
  input  wire logic [4:0]                 i_br_bo,
  input  wire logic [4:0]                 i_br_bi,
  input  wire logic [`RAS_ADDR_W-1:0]     i_br_target,
  input  wire logic [`RAS_ADDR_W-1:0]     i_current_instr_address,
  input  wire logic [`RAS_IQ_IDX_W-1:0]   i_br_iq_slot,
  // link / count forwarding from the complex integer unit station 0
  input  wire logic                       i_mt_valid,
  input  wire logic                       i_mt_is_count,
  input  wire logic                       i_mt_src_ready,
  input  wire logic [`RAS_ADDR_W-1:0]     i_mt_value,
  // resolution of a predicted return
  input  wire logic                       i_ret_resolve,
  // fetch redirection
  output logic                            o_redirect,
  output logic [`RAS_ADDR_W-1:0]          o_redirect_addr,
  output logic                            o_ret_predicted,
  output logic                            o_ret_stall,
  output logic                            o_mispredict,
  // architected registers seen by the branch unit
  output logic [`RAS_ADDR_W-1:0]          o_return_link_reg,
  output logic [`RAS_ADDR_W-1:0]          o_loop_count_reg,
  // instruction_queue folding
  output logic                            o_fold_now,
  output logic                            o_remove_next,
  output logic [`RAS_IQ_IDX_W-1:0]        o_remove_slot,
  output logic                            o_dispatch_normal
);
  // storage lives in its own module; pairing of calls and returns is kept
  // here, so the stack itself never needs to know the branch kinds
  ras_stack_if st ();

  ras_stack u_stack (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .s       (st.store)
  );

  // ==========================================================
  // decode helpers
  function automatic logic is_capture(input logic [4:0] bo, input logic [4:0] bi,
                                      input logic [31:0] tgt, input logic [31:0] current_instr_address);
    is_capture = (bo == `RAS_BO_SPECIAL) && (bi == `RAS_BI_SPECIAL) &&
                 (tgt == current_instr_address + `RAS_INSTR_BYTES);
  endfunction

  function automatic logic in_window(input logic [`RAS_IQ_IDX_W-1:0] slot);
    in_window = (slot < `RAS_IQ_IDX_W'(`RAS_DISP_WIN));
  endfunction

  // ==========================================================
  // state
  // link readiness is set by a call or a forwarded link move and cleared
  // while a link move still waits for its source; a return inside that
  // window predicts from the stack instead of using a stale link value.
  // only one return is tracked at a time: later returns are ignored until
  // the outstanding one resolves, which keeps pushes and pops paired
  ras_state_t                st_q, st_d;
  logic [`RAS_ADDR_W-1:0]    lr_q, lr_d;
  logic                      lr_ready_q, lr_ready_d;
  logic [`RAS_ADDR_W-1:0]    ctr_q, ctr_d;
  logic [`RAS_ADDR_W-1:0]    pred_q, pred_d;
  logic                      redir_q, redir_d;
  logic [`RAS_ADDR_W-1:0]    raddr_q, raddr_d;
  logic                      rpred_q, rpred_d;
  logic                      stall_q, stall_d;
  logic                      misp_q, misp_d;
  logic                      fold_q, fold_d;
  logic                      rem_q, rem_d;
  logic [`RAS_IQ_IDX_W-1:0]  rslot_q, rslot_d;
  logic                      dnorm_q, dnorm_d;

  logic is_call, is_ret, is_ctr, capture, foldable;
  logic [`RAS_ADDR_W-1:0] next_addr;

  assign is_call   = i_br_valid && (i_br_kind == RAS_BR_CALL);
  assign is_ret    = i_br_valid && (i_br_kind == RAS_BR_RET);
  assign is_ctr    = i_br_valid && (i_br_kind == RAS_BR_CTR);
  assign capture   = is_call && is_capture(i_br_bo, i_br_bi, i_br_target, i_current_instr_address);
  assign next_addr = i_current_instr_address + `RAS_INSTR_BYTES;
  // link-writing or count-modifying branches never fold
  assign foldable  = i_br_valid && (i_br_kind == RAS_BR_OTHER) && !i_br_link;

  // ==========================================================
  // stack commands: capture form skips the push so the stack stays paired
  always_comb begin
    st.push      = is_call && !capture;
    st.push_addr = next_addr;
    // only a return waiting on the link value consults and pops
    st.pop       = is_ret && st_q == RAS_ST_IDLE && !lr_ready_q && st.top_valid;
    st.flush     = misp_d;
  end

  // ==========================================================
  // next values of branch unit state
  always_comb begin
    st_d       = st_q;
    pred_d     = pred_q;
    redir_d    = 1'b0;
    raddr_d    = raddr_q;
    rpred_d    = 1'b0;
    stall_d    = 1'b0;
    misp_d     = 1'b0;

    if (is_call && !capture && i_br_taken) begin
      redir_d = 1'b1;
      raddr_d = i_br_target;
    end
    // capture form falls through, so no redirect at all

    if (is_ctr) begin
      redir_d = 1'b1;
      raddr_d = ctr_q;
    end

    unique case (st_q)
      RAS_ST_IDLE: begin
        if (is_ret) begin
          if (lr_ready_q) begin
            redir_d = 1'b1;
            raddr_d = lr_q;
          end else if (st.top_valid) begin
            redir_d = 1'b1;
            raddr_d = st.top_addr;
            rpred_d = 1'b1;
            pred_d  = st.top_addr;
            st_d    = RAS_ST_PRED;
          end else begin
            stall_d = 1'b1;
            st_d    = RAS_ST_STALL;
          end
        end
      end
      RAS_ST_PRED: begin
        // check guess against the forwarded link value
        if (i_ret_resolve && lr_ready_q) begin
          st_d = RAS_ST_IDLE;
          if (lr_q != pred_q) begin
            misp_d  = 1'b1;
            redir_d = 1'b1;
            raddr_d = lr_q;
          end
        end
      end
      RAS_ST_STALL: begin
        if (lr_ready_q) begin
          redir_d = 1'b1;
          raddr_d = lr_q;
          st_d    = RAS_ST_IDLE;
        end else begin
          stall_d = 1'b1;
        end
      end
    endcase
  end

  // registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_q       <= RAS_ST_IDLE;
      pred_q     <= '0;
      redir_q    <= 1'b0;
      raddr_q    <= '0;
      rpred_q    <= 1'b0;
      stall_q    <= 1'b0;
      misp_q     <= 1'b0;
    end else if (i_ce) begin
      st_q       <= st_d;
      pred_q     <= pred_d;
      redir_q    <= redir_d;
      raddr_q    <= raddr_d;
      rpred_q    <= rpred_d;
      stall_q    <= stall_d;
      misp_q     <= misp_d;
    end
  end

  // ==========================================================
  // architected link and count registers
  always_comb begin
    lr_d       = lr_q;
    lr_ready_d = lr_ready_q;
    ctr_d      = ctr_q;

    // early forwarding once the move sits at station 0 with its source ready
    if (i_mt_valid && i_mt_src_ready) begin
      if (i_mt_is_count) begin
        ctr_d = i_mt_value;
      end else begin
        lr_d       = i_mt_value;
        lr_ready_d = 1'b1;
      end
    end else if (i_mt_valid && !i_mt_is_count) begin
      // a link move still waiting on its source leaves the old value stale
      lr_ready_d = 1'b0;
    end

    // call forms write the architected link register, the capture form too
    if (is_call || (is_ctr && i_br_link)) begin
      lr_d       = next_addr;
      lr_ready_d = 1'b1;
    end
  end

  // link and count registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      lr_q       <= '0;
      lr_ready_q <= 1'b0;
      ctr_q      <= '0;
    end else if (i_ce) begin
      lr_q       <= lr_d;
      lr_ready_q <= lr_ready_d;
      ctr_q      <= ctr_d;
    end
  end

  // ==========================================================
  // folding decisions for simple branches
  always_comb begin
    fold_d  = 1'b0;
    rem_d   = 1'b0;
    rslot_d = rslot_q;
    dnorm_d = 1'b0;
    if (foldable) begin
      if (i_br_taken) begin
        fold_d = 1'b1;
      end else if (in_window(i_br_iq_slot)) begin
        // the window dispatches in order, so these cannot fall through
        dnorm_d = 1'b1;
      end else begin
        // further up the queue the entry is simply dropped next cycle
        rem_d   = 1'b1;
        rslot_d = i_br_iq_slot;
      end
    end
  end

  // folding registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      fold_q  <= 1'b0;
      rem_q   <= 1'b0;
      rslot_q <= '0;
      dnorm_q <= 1'b0;
    end else if (i_ce) begin
      fold_q  <= fold_d;
      rem_q   <= rem_d;
      rslot_q <= rslot_d;
      dnorm_q <= dnorm_d;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign o_redirect        = redir_q;
  assign o_redirect_addr   = raddr_q;
  assign o_ret_predicted   = rpred_q;
  assign o_ret_stall       = stall_q;
  assign o_mispredict      = misp_q;
  assign o_return_link_reg = lr_q;
  assign o_loop_count_reg  = ctr_q;
  assign o_fold_now        = fold_q;
  assign o_remove_next     = rem_q;
  assign o_remove_slot     = rslot_q;
  assign o_dispatch_normal = dnorm_q;
endmodule

// *** testbench/ras_monitor.sv ***
// port-level assertions for the return-address stack predictor
`timescale 1ns/100ps
`include "ras_consts.svh"
module ras_monitor
  import ras_pkg::*;
(
  // clock, reset, enable
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic        i_ce,
  // branch
  input wire logic        i_br_valid,
  input wire logic [3:0]  i_br_kind,
  input wire logic        i_br_link,
  input wire logic        i_br_taken,
  input wire logic [4:0]  i_br_bo,
  input wire logic [4:0]  i_br_bi,
  input wire logic [31:0] i_br_target,
  input wire logic [31:0] i_current_instr_address,
  input wire logic [2:0]  i_br_iq_slot,
  // forwarding
  input wire logic        i_mt_valid,
  input wire logic        i_mt_is_count,
  input wire logic        i_mt_src_ready,
  input wire logic [31:0] i_mt_value,
  // outputs
  input wire logic        o_redirect,
  input wire logic [31:0] o_redirect_addr,
  input wire logic        o_ret_stall,
  input wire logic [31:0] o_return_link_reg,
  input wire logic [31:0] o_loop_count_reg,
  input wire logic        o_fold_now,
  input wire logic        o_remove_next,
  input wire logic [2:0]  o_remove_slot
);
  // ====
  // helper terms
  logic br, cap, fwd, fold;
  assign br = i_ce && i_br_valid;
  assign cap = i_br_bo == `RAS_BO_SPECIAL && i_br_bi == `RAS_BI_SPECIAL
               && i_br_target == i_current_instr_address + `RAS_INSTR_BYTES;
  assign fwd = i_ce && i_mt_valid && i_mt_src_ready;
  assign fold = br && i_br_kind == RAS_BR_OTHER && !i_br_link;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ====
  // steps of a call and of a stall release
  sequence s_call;
    br && i_br_kind == RAS_BR_CALL && !fwd;
  endsequence
  sequence s_link_fwd;
    o_ret_stall && fwd && !i_mt_is_count;
  endsequence
  // ====
  // assertions
  chk_call_link: assert property (s_call |=>
    o_return_link_reg == $past(i_current_instr_address) + `RAS_INSTR_BYTES) else $error("call link wrong");
  chk_capture_quiet: assert property (s_call ##0 cap |=> !o_redirect) else $error("capture redirected");
  chk_count_target: assert property (br && i_br_kind == RAS_BR_CTR && i_br_taken && !fwd |=>
    o_redirect && o_redirect_addr == o_loop_count_reg) else $error("count target wrong");
  chk_stall_cause: assert property ($rose(o_ret_stall) |->
    $past(br) && $past(i_br_kind) == RAS_BR_RET) else $error("stall without return");
  chk_link_release: assert property (s_link_fwd |=> o_return_link_reg == $past(i_mt_value)
    ##[0:1] (o_redirect && o_redirect_addr == o_return_link_reg)) else $error("stall release wrong");
  chk_count_fwd: assert property (fwd && i_mt_is_count |=>
    o_loop_count_reg == $past(i_mt_value)) else $error("count forward lost");
  chk_fold_taken: assert property (fold && i_br_taken |=> o_fold_now) else $error("taken not folded");
  chk_remove_slot: assert property (fold && !i_br_taken && i_br_iq_slot >= 3'h3 |=>
    o_remove_next && o_remove_slot == $past(i_br_iq_slot)) else $error("removal wrong");
endmodule
bind ras_predictor ras_monitor i_mon (.*);

// *** testbench/ras_iu_model.sv ***
// behavioural integer-unit station forwarding link and count values
`timescale 1ns/100ps
module ras_iu_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // move request from the bench
  input  wire logic        i_req,
  input  wire logic        i_req_count,
  input  wire logic [31:0] i_req_value,
  input  wire logic [3:0]  i_req_delay,
  // forwarding to the branch unit
  output logic             o_mt_valid,
  output logic             o_mt_is_count,
  output logic             o_mt_src_ready,
  output logic [31:0]      o_mt_value
);
  logic [3:0] wait_q;
  // a move waits for its source, forwards once, then lets go
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_mt_valid <= 1'b0;
      o_mt_src_ready <= 1'b0;
      o_mt_is_count <= 1'b0;
      o_mt_value <= 32'h0;
      wait_q <= 4'h0;
    end else if (i_req) begin
      o_mt_valid <= 1'b1;
      o_mt_is_count <= i_req_count;
      o_mt_value <= i_req_value;
      o_mt_src_ready <= (i_req_delay == 4'h0);
      wait_q <= i_req_delay;
    end else if (o_mt_src_ready) begin
      o_mt_valid <= 1'b0;
      o_mt_src_ready <= 1'b0;
      o_mt_value <= ~o_mt_value; // stale value must not look valid
    end else if (o_mt_valid) begin
      o_mt_src_ready <= (wait_q <= 4'h1);
      wait_q <= wait_q - 4'h1;
    end
  end
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench for the return-address stack predictor
`timescale 1ns/100ps
module tb_top
  import ras_pkg::*;
;
  // ====
  // signals
  typedef struct packed {
    logic [3:0] kind; logic lnk; logic tkn; logic [4:0] bo; logic [4:0] bi;
    logic [31:0] tgt; logic [31:0] current_instr_address; logic [2:0] slot; logic red; logic [31:0] addr; logic [2:0] fx;
  } ras_row_t;
  logic        i_clk = 1'b0, i_reset = 1'b1, i_ce = 1'b1, i_br_valid = 1'b0, i_ret_resolve = 1'b0;
  logic        i_br_link = 1'b0, i_br_taken = 1'b0, p_req = 1'b0, p_cnt = 1'b0;
  logic [3:0]  i_br_kind = 4'h1, p_dly = 4'h0;
  logic [4:0]  i_br_bo = 5'h0, i_br_bi = 5'h0;
  logic [31:0] i_br_target = 32'h0, i_current_instr_address = 32'h0, p_val = 32'h0, i_mt_value;
  logic [2:0]  i_br_iq_slot = 3'h0, o_remove_slot;
  logic        i_mt_valid, i_mt_is_count, i_mt_src_ready, o_redirect, o_ret_predicted, o_ret_stall;
  logic        o_mispredict, o_fold_now, o_remove_next, o_dispatch_normal;
  logic [31:0] o_redirect_addr, o_return_link_reg, o_loop_count_reg;
  int          fails = 0, compares = 0, n;
  ras_row_t    rows [9];
  ras_predictor i_dut (.*);
  ras_iu_model i_iu (.i_clk(i_clk), .i_reset(i_reset), .i_req(p_req), .i_req_count(p_cnt),
    .i_req_value(p_val), .i_req_delay(p_dly), .o_mt_valid(i_mt_valid), .o_mt_is_count(i_mt_is_count),
    .o_mt_src_ready(i_mt_src_ready), .o_mt_value(i_mt_value));
  // ====
  // clock and tasks
  initial begin
    forever #25 i_clk = ~i_clk;
  end
  task automatic cmp_addr(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_addr({31'h0, got}, {31'h0, exp});
  endtask
  task automatic drive(input ras_row_t r);
    @(posedge i_clk);
    i_br_valid <= 1'b1;
    {i_br_kind, i_br_link, i_br_taken, i_br_bo, i_br_bi} <= {r.kind, r.lnk, r.tkn, r.bo, r.bi};
    {i_br_target, i_current_instr_address, i_br_iq_slot} <= {r.tgt, r.current_instr_address, r.slot};
  endtask
  // lets the taking edge pass, then looks after its updates
  task automatic settle;
    @(posedge i_clk);
    i_br_valid <= 1'b0;
    #1;
  endtask
  task automatic forward(input logic cnt, input logic [31:0] val, input logic [3:0] dly);
    @(posedge i_clk);
    {p_req, p_cnt, p_val, p_dly} <= {1'b1, cnt, val, dly};
    @(posedge i_clk);
    p_req <= 1'b0;
    #1;
  endtask
  // a call like the first table row from another address
  task automatic call_at(input logic [31:0] current_instr_address);
    ras_row_t r;
    r = rows[0];
    r.current_instr_address = current_instr_address;
    drive(r);
  endtask
  // a return while a link move still waits: predicted from the stack or stalled
  task automatic pred_ret(input logic [31:0] lnk, input logic [31:0] guess, input logic stall);
    forward(1'b0, lnk, 4'h6);
    drive(rows[1]);
    settle();
    cmp_bit(o_ret_predicted, !stall);
    cmp_bit(o_ret_stall, stall);
    if (!stall) cmp_addr(o_redirect_addr, guess);
    repeat (5) @(posedge i_clk);
    i_ret_resolve <= 1'b1;
    @(posedge i_clk);
    i_ret_resolve <= 1'b0;
    #1;
    cmp_bit(o_mispredict, !stall && lnk != guess);
    cmp_addr(o_redirect_addr, lnk);
  endtask
  task automatic stop_test;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ====
  // tests
  initial begin
    rows = '{
      '{RAS_BR_CALL, 1'b1, 1'b1, 5'h0, 5'h0, 32'h2000, 32'h100, 3'h0, 1'b1, 32'h2000, 3'h0},
      '{RAS_BR_RET, 1'b0, 1'b1, 5'h0, 5'h0, 32'h0, 32'h2000, 3'h0, 1'b1, 32'h104, 3'h0},
      '{RAS_BR_CALL, 1'b1, 1'b1, 5'h14, 5'h1F, 32'h304, 32'h300, 3'h0, 1'b0, 32'h0, 3'h0},
      '{RAS_BR_CTR, 1'b0, 1'b1, 5'h0, 5'h0, 32'h0, 32'h400, 3'h0, 1'b1, 32'h8000, 3'h0},
      '{RAS_BR_OTHER, 1'b0, 1'b1, 5'h0, 5'h0, 32'h600, 32'h500, 3'h0, 1'b0, 32'h0, 3'h4},
      '{RAS_BR_OTHER, 1'b0, 1'b0, 5'h0, 5'h0, 32'h600, 32'h500, 3'h2, 1'b0, 32'h0, 3'h1},
      '{RAS_BR_OTHER, 1'b0, 1'b0, 5'h0, 5'h0, 32'h600, 32'h500, 3'h3, 1'b0, 32'h0, 3'h2},
      '{RAS_BR_OTHER, 1'b0, 1'b0, 5'h0, 5'h0, 32'h600, 32'h500, 3'h7, 1'b0, 32'h0, 3'h2},
      '{RAS_BR_OTHER, 1'b1, 1'b0, 5'h0, 5'h0, 32'h600, 32'h500, 3'h5, 1'b0, 32'h0, 3'h0}};
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
    // a return before any link value must wait for the forward
    drive(rows[1]);
    settle();
    cmp_bit(o_ret_stall, 1'b1);
    forward(1'b0, 32'h4440, 4'h3);
    cmp_bit(o_ret_stall, 1'b1);
    n = 0;
    while (o_redirect !== 1'b1 && n < 20) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    cmp_bit(o_redirect, 1'b1);
    cmp_addr(o_redirect_addr, 32'h4440);
    forward(1'b1, 32'h8000, 4'h0);
    repeat (2) @(posedge i_clk);
    #1;
    cmp_addr(o_loop_count_reg, 32'h8000);
    $display("test stall done");
    foreach (rows[i]) begin
      drive(rows[i]);
      settle();
      if (rows[i].kind !== RAS_BR_OTHER) begin
        cmp_bit(o_redirect, rows[i].red);
        if (rows[i].red) cmp_addr(o_redirect_addr, rows[i].addr);
      end else begin
        cmp_bit(o_fold_now, rows[i].fx[2]);
        cmp_bit(o_remove_next, rows[i].fx[1]);
        cmp_bit(o_dispatch_normal, rows[i].fx[0]);
        if (rows[i].fx[1]) cmp_addr({29'h0, o_remove_slot}, {29'h0, rows[i].slot});
      end
    end
    cmp_addr(o_return_link_reg, 32'h304);
    $display("test table done");
    // second reset, then call and return back to back
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    drive(rows[0]);
    drive(rows[1]);
    #1;
    cmp_addr(o_redirect_addr, 32'h2000);
    settle();
    cmp_bit(o_ret_stall, 1'b0);
    cmp_addr(o_redirect_addr, 32'h104);
    $display("test reset done");
    // three calls deep, then returns while each link move is still pending
    call_at(32'h0000_0200);
    call_at(32'h0000_0300);
    settle();
    cmp_addr(o_return_link_reg, 32'h0000_0304);
    pred_ret(32'h0000_0304, 32'h0000_0304, 1'b0);
    pred_ret(32'h0000_0999, 32'h0000_0204, 1'b0);
    pred_ret(32'h0000_0ABC, 32'h0000_0000, 1'b1);
    $display("test prediction done");
    stop_test();
  end
  // about 80 cycles are needed; 2000 is ample
  initial begin
    #(2000 * 50);
    fails++;
    stop_test();
  end
endmodule
